// ### shared/eeac_defines.vh
// constants for the data nonvolatile byte access controller
// assumes a 40 MHz cpu clock and an rc timebase derived from it
`ifndef EEAC_DEFINES_VH
`define EEAC_DEFINES_VH

// register select codes on the i/o port
`define EEAC_SEL_ADDR_LOW 2'h0
`define EEAC_SEL_ADDR_HIGH 2'h1
`define EEAC_SEL_DATA 2'h2
`define EEAC_SEL_CTRL 2'h3

// control register field positions
`define EEAC_CTL_MODE_HI 5
`define EEAC_CTL_MODE_LO 4
`define EEAC_CTL_RIE 3
`define EEAC_CTL_ARM 2
`define EEAC_CTL_WSTB 1
`define EEAC_CTL_RSTB 0

// programming modes
`define EEAC_MODE_ATOMIC 2'h0
`define EEAC_MODE_ERASE 2'h1
`define EEAC_MODE_WRITE 2'h2

// reset values and the erased byte value
`define EEAC_DATA_RST 8'h00
`define EEAC_MODE_RST 2'h0
`define EEAC_ERASED_BYTE 8'hFF

// timing
`define EEAC_CLK_KHZ 40000
`define EEAC_ARM_CYCLES 3'h4
`define EEAC_RD_STALL 3'h4
`define EEAC_WR_STALL 3'h2
// sized to match the 15 bit timer load
`define EEAC_ATOMIC_RC_CYCLES 15'h6700
`define EEAC_ATOMIC_TIME_US 3300
`define EEAC_SPLIT_TIME_US 1800
// rc cycles for the shorter modes: the atomic count scaled to the
// shorter time and rounded up
`define EEAC_SPLIT_RC_CYCLES 15'h382f
// cpu clocks per rc oscillator cycle
`define EEAC_RC_DIV ((`EEAC_CLK_KHZ * `EEAC_ATOMIC_TIME_US) / \
  (`EEAC_ATOMIC_RC_CYCLES * 1000))

`endif

// ### rtl/eeac_nvm_array.v
// byte array that stands for the nonvolatile cells
// assumes one read or one write per cycle, issued by the controller
`timescale 1ns/1ps
module eeac_nvm_array (
  // clock
  input wire clk,
  // read port
  input wire rd_en,
  input wire [8:0] rd_addr,
  output reg [7:0] rd_data_q,
  // write port
  input wire wr_en,
  input wire [8:0] wr_addr,
  input wire [7:0] wr_data
);

  // cell storage, 512 bytes, never reset since it is nonvolatile
  reg [7:0] cells [0:511];

  // ----------------------------------------
  // registered read and plain write
  // ----------------------------------------
  always @(posedge clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_q <= cells[rd_addr];
    end
  end

endmodule

// ### rtl/eeac_prog_timer.v
// self timer for one programming operation
// assumes start is a one-cycle pulse and only comes while idle
`timescale 1ns/1ps
`include "eeac_defines.vh"
module eeac_prog_timer (
  // clock and reset
  input wire clk,
  input wire reset,
  // control
  input wire start,
  input wire [14:0] rc_cycles,
  // status
  output reg done_q,
  output reg running_q
);

  reg [2:0] div_q; // cpu clocks within one rc cycle
  reg [14:0] left_q; // rc cycles still to run
  wire rc_tick; // one pulse per rc oscillator cycle
  wire [31:0] rc_div_last; // last divider count of one rc cycle

  assign rc_div_last = `EEAC_RC_DIV - 1;
  assign rc_tick = (div_q == rc_div_last[2:0]);

  // ----------------------------------------
  // rc timebase divider
  // ----------------------------------------
  // free running, so an operation may lose part of one rc cycle at
  // start; that is far below the oscillator's own tolerance
  // it keeps running through a reset while an operation is busy
  always @(posedge clk) begin
    if ((reset && !running_q) || rc_tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // ----------------------------------------
  // rc cycle down counter
  // ----------------------------------------
  // a reset during programming lets the operation count on and finish
  always @(posedge clk) begin
    done_q <= 1'b0;
    if (reset && !running_q) begin
      running_q <= 1'b0;
      left_q <= 15'h0000;
    end else if (start && !reset) begin
      running_q <= 1'b1;
      left_q <= rc_cycles;
    end else if (running_q && rc_tick) begin
      if (left_q == 15'h0001) begin
        running_q <= 1'b0;
        done_q <= 1'b1;
      end
      left_q <= left_q - 15'h0001;
    end
  end

endmodule

// ### rtl/eeac_ctrl.v
// cpu facing access controller for the 512 byte data array
// assumes the cpu honours stall_q and flash_selfprog_busy comes
// from logic on the same clock
`timescale 1ns/1ps
`include "eeac_defines.vh"
module eeac_ctrl #(
  // programming lengths in rc cycles, shorten for simulation
  parameter [14:0] ATOMIC_RC_CYCLES = `EEAC_ATOMIC_RC_CYCLES,
  parameter [14:0] SPLIT_RC_CYCLES = `EEAC_SPLIT_RC_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // i/o register port
  input wire io_wr,
  input wire io_rd,
  input wire [1:0] io_sel,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_q,
  // cpu side
  output reg cpu_stall_q,
  input wire global_irq_enable,
  output reg ready_irq_q,
  // flash self programming status
  input wire flash_selfprog_busy
);

  // ----------------------------------------
  // programming sequencer states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001; // no array write
  localparam [2:0] ST_FETCH = 3'b010; // old byte being read
  localparam [2:0] ST_PROG = 3'b100; // timed programming

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [2:0] state_q; // sequencer state
  reg [8:0] nvm_address_q; // software address
  reg [7:0] nvm_data_byte_q; // software data
  reg [1:0] mode_q; // programming mode bits
  reg ready_irq_enable_q; // ready interrupt enable
  reg [2:0] arm_cnt_q; // cycles left on the write arm
  reg read_strobe_q; // read in flight
  reg [2:0] stall_cnt_q; // cpu stall cycles left
  reg [8:0] prog_addr_q; // address latched at strobe
  reg [7:0] prog_data_q; // data latched at strobe
  reg [1:0] prog_mode_q; // mode latched at strobe
  reg [7:0] prog_byte_q; // byte to commit to the array

  // ----------------------------------------
  // decoded signals
  // ----------------------------------------
  wire busy; // array write in progress
  wire master_write_arm; // arm window open
  wire write_strobe; // control bit as software sees it
  wire ctrl_wr; // software writes control
  wire strobe_req; // software asks for a write
  wire wr_accept; // write actually starts
  wire rd_accept; // read actually starts
  wire arm_set; // software sets the arm bit
  wire mode_ok; // mode is not the reserved one
  wire [7:0] ctrl_rd; // control register read value
  wire tmr_done; // programming time elapsed
  wire tmr_running; // timer still counting
  wire [7:0] arr_rdata; // array read data
  reg [2:0] stall_cnt_d; // next stall count
  reg [2:0] arm_cnt_d; // next arm count
  reg [7:0] merged_byte; // byte after mode is applied

  assign busy = ~state_q[0];
  assign write_strobe = busy;
  assign master_write_arm = (arm_cnt_q != 3'h0);
  assign ctrl_wr = io_wr && (io_sel == `EEAC_SEL_CTRL);
  assign arm_set = ctrl_wr && io_wdata[`EEAC_CTL_ARM];
  assign mode_ok = (mode_q != 2'h3); // reserved mode does nothing
  assign strobe_req = ctrl_wr && io_wdata[`EEAC_CTL_WSTB];
  // the arm must already be open; arm and strobe in one write fails
  assign wr_accept = strobe_req && master_write_arm && !busy
    && !tmr_running // the timer must be free as well
    && !flash_selfprog_busy && mode_ok;
  // reads are refused outright while a write is running
  assign rd_accept = ctrl_wr && io_wdata[`EEAC_CTL_RSTB]
    && !busy && !read_strobe_q;

  // control register as read back, top bits fixed at zero
  assign ctrl_rd = {2'b00, mode_q, ready_irq_enable_q,
    master_write_arm, write_strobe, read_strobe_q};

  // ----------------------------------------
  // array and timer
  // ----------------------------------------
  eeac_nvm_array u_array (
    .clk(clk),
    .rd_en(rd_accept || wr_accept),
    .rd_addr(nvm_address_q),
    .rd_data_q(arr_rdata),
    .wr_en(tmr_done && state_q[2]),
    .wr_addr(prog_addr_q),
    .wr_data(prog_byte_q)
  );

  eeac_prog_timer u_timer (
    .clk(clk),
    .reset(reset),
    .start(wr_accept),
    .rc_cycles((mode_q == `EEAC_MODE_ATOMIC) ? ATOMIC_RC_CYCLES
      : SPLIT_RC_CYCLES),
    .done_q(tmr_done),
    .running_q(tmr_running)
  );

  // ----------------------------------------
  // byte that the latched mode will program
  // ----------------------------------------
  // write only can clear bits but never set them, so it merges with
  // the old cell content; erase only sets every bit
  always @* begin
    case (prog_mode_q)
      `EEAC_MODE_ERASE: merged_byte = `EEAC_ERASED_BYTE;
      `EEAC_MODE_WRITE: merged_byte = arr_rdata & prog_data_q;
      default: merged_byte = prog_data_q;
    endcase
  end

  // ----------------------------------------
  // programming sequencer
  // ----------------------------------------
  // a reset while busy must not cut the operation short, so the
  // busy states survive reset; every other value goes to idle
  always @(posedge clk) begin
    if (reset) begin
      case (state_q)
        ST_FETCH: ; // hold the fetch state until reset is released
        ST_PROG: begin
          // the timer may end while reset is still held
          if (tmr_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_accept) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_q <= ST_PROG;
        end
        ST_PROG: begin
          if (tmr_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // operation latches
  // ----------------------------------------
  // the latches free the data register for the next write; mode and address stay frozen while busy, and a reset while busy keeps mode_q but clears nvm_address_q
  always @(posedge clk) begin
    if (wr_accept) begin
      prog_addr_q <= nvm_address_q;
      prog_data_q <= nvm_data_byte_q;
      prog_mode_q <= mode_q;
    end
    if (state_q[1]) begin
      prog_byte_q <= merged_byte;
    end
  end

  // ----------------------------------------
  // address register
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      nvm_address_q <= 9'h000;
    end else if (io_wr && !busy) begin
      if (io_sel == `EEAC_SEL_ADDR_LOW) begin
        nvm_address_q[7:0] <= io_wdata;
      end else if (io_sel == `EEAC_SEL_ADDR_HIGH) begin
        nvm_address_q[8] <= io_wdata[0];
      end
    end
  end

  // ----------------------------------------
  // data register
  // ----------------------------------------
  // the array result wins over a software write in the same cycle
  always @(posedge clk) begin
    if (reset) begin
      nvm_data_byte_q <= `EEAC_DATA_RST;
    end else if (read_strobe_q) begin
      nvm_data_byte_q <= arr_rdata;
    end else if (io_wr && (io_sel == `EEAC_SEL_DATA)) begin
      nvm_data_byte_q <= io_wdata;
    end
  end

  // ----------------------------------------
  // mode and enable bits
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      ready_irq_enable_q <= 1'b0;
      case (state_q)
        ST_FETCH, ST_PROG: ; // keep mode while busy
        default: mode_q <= `EEAC_MODE_RST;
      endcase
    end else if (ctrl_wr) begin
      ready_irq_enable_q <= io_wdata[`EEAC_CTL_RIE];
      if (!busy) begin
        mode_q <= io_wdata[`EEAC_CTL_MODE_HI:`EEAC_CTL_MODE_LO];
      end
    end
  end

  // ----------------------------------------
  // write arm window
  // ----------------------------------------
  // a fresh set restarts the window, even in its last cycle
  always @* begin
    if (arm_set) begin
      arm_cnt_d = `EEAC_ARM_CYCLES;
    end else if (ctrl_wr) begin
      arm_cnt_d = 3'h0; // software wrote the bit as zero
    end else if (master_write_arm) begin
      arm_cnt_d = arm_cnt_q - 3'h1;
    end else begin
      arm_cnt_d = 3'h0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      arm_cnt_q <= 3'h0;
    end else begin
      arm_cnt_q <= arm_cnt_d;
    end
  end

  // ----------------------------------------
  // read strobe
  // ----------------------------------------
  // high for the one cycle in which the array answers
  always @(posedge clk) begin
    if (reset) begin
      read_strobe_q <= 1'b0;
    end else begin
      read_strobe_q <= rd_accept;
    end
  end

  // ----------------------------------------
  // cpu stall
  // ----------------------------------------
  always @* begin
    if (rd_accept) begin
      stall_cnt_d = `EEAC_RD_STALL;
    end else if (wr_accept) begin
      stall_cnt_d = `EEAC_WR_STALL;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_d = stall_cnt_q - 3'h1;
    end else begin
      stall_cnt_d = 3'h0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      stall_cnt_q <= 3'h0;
      cpu_stall_q <= 1'b0;
    end else begin
      stall_cnt_q <= stall_cnt_d;
      cpu_stall_q <= (stall_cnt_d != 3'h0);
    end
  end

  // ----------------------------------------
  // ready interrupt
  // ----------------------------------------
  // level request, no flag: it drops as soon as its cause goes
  always @(posedge clk) begin
    if (reset) begin
      ready_irq_q <= 1'b0;
    end else begin
      ready_irq_q <= ready_irq_enable_q && global_irq_enable
        && !wr_accept && !busy && !flash_selfprog_busy;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      io_rdata_q <= 8'h00;
    end else if (io_rd) begin
      case (io_sel)
        `EEAC_SEL_ADDR_LOW: io_rdata_q <= nvm_address_q[7:0];
        `EEAC_SEL_ADDR_HIGH: io_rdata_q <= {7'h00, nvm_address_q[8]};
        `EEAC_SEL_DATA: io_rdata_q <= nvm_data_byte_q;
        default: io_rdata_q <= ctrl_rd;
      endcase
    end
  end

endmodule

// ### verification/eeac_ctrl_sva.sv
// checker for the data byte access controller, ports only
// assumes the cpu honours the stall and sends one byte per access
`timescale 1ns/1ps
module eeac_ctrl_sva #(
  parameter [14:0] ATOMIC_RC_CYCLES = 15'h6700,
  parameter [14:0] SPLIT_RC_CYCLES = 15'h382f
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // register port
  input wire io_wr,
  input wire io_rd,
  input wire [1:0] io_sel,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata_q,
  // cpu side
  input wire cpu_stall_q,
  input wire global_irq_enable,
  input wire ready_irq_q,
  input wire flash_selfprog_busy
);
  // --------------------------------------------------------------
  // one domain, so one clock and one disable
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a control register write from the cpu
  wire ctl_wr = io_wr && io_sel == 2'h3;
  a_addr_hi_zero: assert property (io_rd && io_sel == 2'h1 |=>
    io_rdata_q[7:1] == 7'h00) else $error("address top bits not zero");
  a_ctrl_top_zero: assert property (io_rd && io_sel == 2'h3 |=>
    io_rdata_q[7:6] == 2'h0) else $error("control top bits not zero");
  a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata_q))
    else $error("read data moved without a read");
  a_stall_cause: assert property ($rose(cpu_stall_q) |->
    $past(ctl_wr && io_wdata[1:0] != 2'h0)) else $error("stray stall");
  a_read_stall: assert property ($rose(cpu_stall_q) &&
    $past(io_wdata[1:0]) == 2'h1 |-> cpu_stall_q [*4] ##1 !cpu_stall_q)
    else $error("read stall is not four cycles");
  a_write_stall: assert property ($rose(cpu_stall_q) &&
    $past(io_wdata[1:0]) == 2'h2 |-> cpu_stall_q [*2] ##1 !cpu_stall_q)
    else $error("write stall is not two cycles");
  a_irq_needs_gie: assert property (!global_irq_enable |=>
    !ready_irq_q) else $error("ready irq without global enable");
  a_irq_selfprog: assert property (flash_selfprog_busy |=>
    !ready_irq_q) else $error("ready irq during self programming");
  // a two cycle stall marks a write that has just been launched
  a_irq_write_low: assert property ($fell(cpu_stall_q) &&
    !$past(cpu_stall_q, 3) |-> !ready_irq_q [*8])
    else $error("ready irq while a write runs");
endmodule
bind eeac_ctrl eeac_ctrl_sva #(
  .ATOMIC_RC_CYCLES(ATOMIC_RC_CYCLES),
  .SPLIT_RC_CYCLES(SPLIT_RC_CYCLES)
) eeac_ctrl_sva_i (.clk(clk), .reset(reset), .io_wr(io_wr),
  .io_rd(io_rd), .io_sel(io_sel), .io_wdata(io_wdata),
  .io_rdata_q(io_rdata_q), .cpu_stall_q(cpu_stall_q),
  .global_irq_enable(global_irq_enable), .ready_irq_q(ready_irq_q),
  .flash_selfprog_busy(flash_selfprog_busy));

// ### verification/tb_top.sv
// self checking bench for the data byte access controller
// assumes shortened programming counts and a 40 mhz clock
`timescale 1ns/1ps
module tb_top;
  // shortened rc counts keep an atomic write near a hundred clocks and a split mode write near fifty
  localparam int AT = 20;
  localparam int SP = 10;
  reg clk, reset, io_wr, io_rd, global_irq_enable, flash_selfprog_busy;
  reg [1:0] io_sel;
  reg [7:0] io_wdata;
  wire [7:0] io_rdata_q;
  wire cpu_stall_q, ready_irq_q;
  int bad_count = 0, num_checks = 0, cyc = 0;
  eeac_ctrl #(.ATOMIC_RC_CYCLES(AT), .SPLIT_RC_CYCLES(SP)) eeac_ctrl_i (
    .clk(clk), .reset(reset), .io_wr(io_wr), .io_rd(io_rd),
    .io_sel(io_sel), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
    .cpu_stall_q(cpu_stall_q), .global_irq_enable(global_irq_enable),
    .ready_irq_q(ready_irq_q), .flash_selfprog_busy(flash_selfprog_busy));
  // ------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string n, input [7:0] s, input [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // the bench is the cpu, so it waits out any stall first
  task wr(input [1:0] s, input [7:0] d);
    @(negedge clk);
    while (cpu_stall_q === 1'b1) @(negedge clk);
    io_wr = 1'b1;
    io_sel = s;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  task rd(input [1:0] s, output [7:0] v);
    @(negedge clk);
    while (cpu_stall_q === 1'b1) @(negedge clk);
    io_rd = 1'b1;
    io_sel = s;
    @(negedge clk);
    io_rd = 1'b0;
    v = io_rdata_q;
  endtask
  task rchk(input string n, input [1:0] s, input [7:0] e);
    reg [7:0] v;
    rd(s, v);
    chk(n, v, e);
  endtask
  // polls the write strobe, counting cycles, bounded
  task wait_idle(output int n);
    reg [7:0] v;
    n = 0;
    v = 8'h02;
    while (v[1] !== 1'b0 && n < 400) begin
      rd(2'h3, v);
      n += 2;
    end
  endtask
  task pulse;
    @(negedge clk) reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    rchk("addr low", 2'h0, 8'h00);
    rchk("addr high", 2'h1, 8'h00);
    rchk("data", 2'h2, 8'h00);
    rchk("control", 2'h3, 8'h00);
  endtask
  task t_arm;
    wr(2'h3, 8'h04);
    rchk("arm open", 2'h3, 8'h04);
    repeat (3) @(negedge clk);
    rchk("arm closed", 2'h3, 8'h00);
    wr(2'h3, 8'h02);
    chk("stall", {7'h00, cpu_stall_q}, 8'h00);
    wr(2'h3, 8'h04);
    repeat (4) @(negedge clk);
    wr(2'h3, 8'h02);
    rchk("late strobe", 2'h3, 8'h00);
  endtask
  // arms, strobes, times the write and reads the byte back
  task prog(input [1:0] m, input [8:0] a, input [7:0] d, input [7:0] e);
    int n, t;
    wr(2'h0, a[7:0]);
    wr(2'h1, {7'h00, a[8]});
    wr(2'h2, d);
    wr(2'h3, {2'h0, m, 4'h4});
    wr(2'h3, {2'h0, m, 4'h6});
    wait_idle(n);
    t = (m == 2'h0 ? AT : SP) * 5;
    chk("prog time", {7'h00, n >= t - 12 && n <= t + 12}, 8'h01);
    wr(2'h3, 8'h01);
    rchk("array byte", 2'h2, e);
  endtask
  task t_modes;
    prog(2'h0, 9'h1a5, 8'h5a, 8'h5a);
    prog(2'h1, 9'h1a5, 8'h00, 8'hff);
    prog(2'h2, 9'h1a5, 8'h3c, 8'h3c);
    prog(2'h2, 9'h1a5, 8'h0f, 8'h0c);
    prog(2'h0, 9'h1ff, 8'ha7, 8'ha7);
    prog(2'h0, 9'h000, 8'h11, 8'h11);
    wr(2'h0, 8'hff);
    wr(2'h1, 8'h01);
    wr(2'h3, 8'h01);
    rchk("top byte", 2'h2, 8'ha7);
    rchk("read strobe clear", 2'h3, 8'h00);
    wr(2'h3, 8'h34);
    wr(2'h3, 8'h36);
    chk("reserved mode", {7'h00, cpu_stall_q}, 8'h00);
  endtask
  task t_busy;
    int n;
    wr(2'h0, 8'h03);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h42);
    wr(2'h3, 8'h04);
    wr(2'h3, 8'h06);
    wr(2'h3, 8'h11);
    chk("busy read", {7'h00, cpu_stall_q}, 8'h00);
    rchk("frozen mode", 2'h3, 8'h02);
    wr(2'h0, 8'h77);
    rchk("frozen addr", 2'h0, 8'h03);
    wait_idle(n);
    wr(2'h3, 8'h01);
    rchk("busy byte", 2'h2, 8'h42);
  endtask
  task t_irq;
    int n;
    @(negedge clk) global_irq_enable = 1'b1;
    wr(2'h3, 8'h08);
    repeat (2) @(negedge clk);
    chk("irq idle", {7'h00, ready_irq_q}, 8'h01);
    flash_selfprog_busy = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq selfprog", {7'h00, ready_irq_q}, 8'h00);
    wr(2'h3, 8'h0c);
    wr(2'h3, 8'h0a);
    chk("strobe selfprog", {7'h00, cpu_stall_q}, 8'h00);
    flash_selfprog_busy = 1'b0;
    repeat (6) @(negedge clk);
    chk("irq back", {7'h00, ready_irq_q}, 8'h01);
    wr(2'h3, 8'h0c);
    wr(2'h3, 8'h0a);
    repeat (3) @(negedge clk);
    chk("irq writing", {7'h00, ready_irq_q}, 8'h00);
    wait_idle(n);
    repeat (2) @(negedge clk);
    chk("irq done", {7'h00, ready_irq_q}, 8'h01);
    global_irq_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk("irq masked", {7'h00, ready_irq_q}, 8'h00);
  endtask
  task t_reset_prog;
    int n;
    wr(2'h3, 8'h24);
    wr(2'h3, 8'h26);
    pulse();
    rchk("kept mode", 2'h3, 8'h22);
    wait_idle(n);
    pulse();
    rchk("cleared mode", 2'h3, 8'h00);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_sel = 2'h0;
    io_wdata = 8'h00;
    global_irq_enable = 1'b0;
    flash_selfprog_busy = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    t_reset();
    t_arm();
    t_modes();
    t_busy();
    t_irq();
    t_reset_prog();
    results();
  end
endmodule
